// [rtl/pmc_pkg.sv]
// constants, register map and mode codes for the power mode controller
// Operation
// - writing the power-down bit enters power down; fetching stops until hardware reset.
// - writing the idle bit enters idle; execution suspends right after that write.
// - idle ends only on hardware reset or an enabled interrupt.
// - interrupt wake services the interrupt, then execution resumes after the idle write.
// - in idle or power down the low-order port pins float.
// - control register holds baud doubling bit plus four bits, two general-purpose flags.
// - port releases a pin when one is written, pulls it low when zero.
package pmc_pkg;

  localparam logic [11:0] ADDR_PWR_CTL   = 12'h000;
  localparam logic [11:0] ADDR_PORT0     = 12'h004;
  localparam logic [11:0] ADDR_STAT      = 12'h008;

  localparam int          PC_IDLE        = 0;
  localparam int          PC_PDOWN       = 1;
  localparam int          PC_GF0         = 2;
  localparam int          PC_GF1         = 3;
  localparam int          PC_BAUD        = 7;
  localparam logic [7:0]  PWR_CTL_MASK   = 8'h8F;
  localparam logic [7:0]  PWR_CTL_RST    = 8'h00;
  localparam logic [7:0]  PORT0_RST      = 8'hFF;

  localparam int          STAT_MODE_LSB  = 0;
  localparam int          STAT_PIN_LSB   = 8;

  localparam int          MC_CLKS        = 12;
  localparam int          RST_HOLD_MC    = 2;
  localparam logic [4:0]  RST_HOLD_CLKS  = 5'(MC_CLKS * RST_HOLD_MC);

  typedef enum logic [2:0] {
    PMC_RUN   = 3'b001,
    PMC_IDLE  = 3'b010,
    PMC_PDOWN = 3'b100
  } pmc_mode_e;

endpackage : pmc_pkg

// [rtl/pmc_if.sv]
// link between the register slave and the mode controller
`timescale 1ns/1ps
interface pmc_if;
  logic [7:0]          pwr_ctl;
  logic [7:0]          p0_latch;
  logic                pwr_ctl_wr;
  logic [7:0]          pwr_ctl_wdata;
  logic                clr_idle;
  logic                hw_rst;
  pmc_pkg::pmc_mode_e  mode;
  logic [7:0]          p0_pins;

  modport regs (
    output pwr_ctl, p0_latch, pwr_ctl_wr, pwr_ctl_wdata,
    input  clr_idle, hw_rst, mode, p0_pins
  );
  modport ctl (
    input  pwr_ctl, p0_latch, pwr_ctl_wr, pwr_ctl_wdata,
    output clr_idle, hw_rst, mode, p0_pins
  );
endinterface : pmc_if

// [rtl/pmc_regs.sv]
// apb register slave: power control, port latch and status
`timescale 1ns/1ps
module pmc_regs (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  pmc_if.regs              bus
);

  logic        acc;
  logic        wr_en;
  logic        hit;
  logic [7:0]  pwr_ctl_r;
  logic [7:0]  p0_r;
  logic [31:0] rdata_r;

  assign acc      = psel & penable;
  assign wr_en    = acc & pwrite;
  assign hit      = (paddr == pmc_pkg::ADDR_PWR_CTL) | (paddr == pmc_pkg::ADDR_PORT0)
                  | (paddr == pmc_pkg::ADDR_STAT);
  assign pready   = acc;
  assign pslverr  = acc & ~hit;
  assign prdata   = rdata_r;

  assign bus.pwr_ctl       = pwr_ctl_r;
  assign bus.p0_latch      = p0_r;
  assign bus.pwr_ctl_wr    = wr_en & (paddr == pmc_pkg::ADDR_PWR_CTL);
  assign bus.pwr_ctl_wdata = pwdata[7:0] & pmc_pkg::PWR_CTL_MASK;

  // software write beats the hardware idle clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctl_r <= pmc_pkg::PWR_CTL_RST;
    end else if (bus.hw_rst) begin
      pwr_ctl_r <= pmc_pkg::PWR_CTL_RST;
    end else if (bus.pwr_ctl_wr) begin
      pwr_ctl_r <= bus.pwr_ctl_wdata;
    end else if (bus.clr_idle) begin
      pwr_ctl_r[pmc_pkg::PC_IDLE] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_r <= pmc_pkg::PORT0_RST;
    end else if (bus.hw_rst) begin
      p0_r <= pmc_pkg::PORT0_RST;
    end else if (wr_en && paddr == pmc_pkg::ADDR_PORT0) begin
      p0_r <= pwdata[7:0];
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_r <= 32'h0000_0000;
      unique case (paddr)
        pmc_pkg::ADDR_PWR_CTL: rdata_r[7:0] <= pwr_ctl_r;
        pmc_pkg::ADDR_PORT0: rdata_r[7:0] <= p0_r;
        pmc_pkg::ADDR_STAT: begin
          rdata_r[pmc_pkg::STAT_MODE_LSB +: 3] <= bus.mode;
          rdata_r[pmc_pkg::STAT_PIN_LSB +: 8]  <= bus.p0_pins;
        end
        default:             rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  gp_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    bus.pwr_ctl_wr && !bus.hw_rst |=> pwr_ctl_r[3:2] == $past(pwdata[3:2])
      && pwr_ctl_r[7] == $past(pwdata[7]) && pwr_ctl_r[6:4] == 3'h0)
    else $error("control register flags not stored");

  unmapped_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    acc && !hit |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule : pmc_regs

// [rtl/pmc_top.sv]
// power mode controller: idle and power-down sequencing, reset filter, port release
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module pmc_top (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rst_pin,
  input  wire logic        irq_req,
  output logic             core_reset,
  output logic             cpu_clk_en,
  output logic             fetch_en,
  output logic             periph_clk_en,
  output logic             irq_wake,
  output logic             baud_double,
  input  wire logic [7:0]  p0_in,
  output logic      [7:0]  p0_out,
  output logic      [7:0]  p0_oe
);

  logic               rst_q1;
  logic               rst_n;
  logic [4:0]         rst_cnt_r;
  logic               hw_rst_r;
  pmc_pkg::pmc_mode_e state_r;
  pmc_pkg::pmc_mode_e state_nxt;
  logic               wake_r;

  pmc_if bus ();

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  pmc_regs pmc_regs_i (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus.regs)
  );

  // reset pin must stay high a full hold time before it counts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_cnt_r <= 5'h00;
    end else if (!rst_pin) begin
      rst_cnt_r <= 5'h00;
    end else if (rst_cnt_r != pmc_pkg::RST_HOLD_CLKS) begin
      rst_cnt_r <= rst_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hw_rst_r <= 1'b0;
    end else begin
      hw_rst_r <= rst_pin && (rst_cnt_r == pmc_pkg::RST_HOLD_CLKS - 5'h01
                              || rst_cnt_r == pmc_pkg::RST_HOLD_CLKS);
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pmc_pkg::PMC_RUN: begin
        if (bus.pwr_ctl_wr && bus.pwr_ctl_wdata[pmc_pkg::PC_PDOWN]) begin
          state_nxt = pmc_pkg::PMC_PDOWN;
        end else if (bus.pwr_ctl_wr && bus.pwr_ctl_wdata[pmc_pkg::PC_IDLE]) begin
          state_nxt = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (irq_req) begin
          state_nxt = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_PDOWN: begin
        state_nxt = pmc_pkg::PMC_PDOWN;
      end
    endcase
    if (hw_rst_r) begin
      state_nxt = pmc_pkg::PMC_RUN;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= pmc_pkg::PMC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one-cycle wake pulse tells the core to take the pending interrupt
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= (state_r == pmc_pkg::PMC_IDLE) && irq_req && !hw_rst_r;
    end
  end

  assign bus.clr_idle = (state_r == pmc_pkg::PMC_IDLE) && irq_req && !hw_rst_r;
  assign bus.hw_rst   = hw_rst_r;
  assign bus.mode     = state_r;
  assign bus.p0_pins  = p0_in;

  assign core_reset    = hw_rst_r;
  assign cpu_clk_en    = state_r[0];
  assign fetch_en      = state_r[0];
  assign periph_clk_en = ~state_r[2];
  assign irq_wake      = wake_r;
  assign baud_double   = bus.pwr_ctl[pmc_pkg::PC_BAUD];

  // open-drain port: drive low only for a zero latch bit while running
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_p0
      assign p0_out[gi] = 1'b0;
      assign p0_oe[gi]  = state_r[0] & ~bus.p0_latch[gi];
    end
  endgenerate

  pdown_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == pmc_pkg::PMC_PDOWN && !hw_rst_r && !irq_req ##1 irq_req
      |-> state_r == pmc_pkg::PMC_PDOWN && !fetch_en)
    else $error("power down left without reset");

  pdown_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == pmc_pkg::PMC_RUN && bus.pwr_ctl_wr && bus.pwr_ctl_wdata[1] && !hw_rst_r
      |=> !fetch_en && !periph_clk_en)
    else $error("power down not entered");

  idle_enter_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == pmc_pkg::PMC_RUN && bus.pwr_ctl_wr
      && bus.pwr_ctl_wdata[1:0] == 2'b01 && !hw_rst_r
      |=> state_r == pmc_pkg::PMC_IDLE && !cpu_clk_en && bus.pwr_ctl[0])
    else $error("idle not entered on write");

  idle_stay_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == pmc_pkg::PMC_IDLE && !irq_req && !hw_rst_r |=> state_r == pmc_pkg::PMC_IDLE)
    else $error("idle ended without cause");

  irq_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == pmc_pkg::PMC_IDLE && irq_req && !hw_rst_r
      |=> cpu_clk_en && irq_wake && !bus.pwr_ctl[0] ##1 !irq_wake)
    else $error("interrupt wake wrong");

  port_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r != pmc_pkg::PMC_RUN |-> p0_oe == 8'h00)
    else $error("port driven in low power mode");

  port_drive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(state_r == pmc_pkg::PMC_RUN && bus.pwr_ctl_wr == 1'b0) && state_r == pmc_pkg::PMC_RUN
      |-> p0_oe == ~bus.p0_latch && p0_out == 8'h00)
    else $error("port drive does not follow latch");

  hw_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(hw_rst_r) |-> $past(rst_cnt_r) == pmc_pkg::RST_HOLD_CLKS - 5'h01 ##1
      state_r == pmc_pkg::PMC_RUN && bus.pwr_ctl == 8'h00)
    else $error("reset pin filter wrong");

  idle_periph_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == pmc_pkg::PMC_IDLE |-> periph_clk_en && !fetch_en)
    else $error("peripheral clock stopped in idle");

  // an interrupt outside idle must never raise the wake pulse
  run_no_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r != pmc_pkg::PMC_IDLE |=> !irq_wake)
    else $error("wake pulse outside idle");

endmodule : pmc_top

// [bench/pmc_bench.sv]
// self-checking testbench for the power mode controller
`timescale 1ns/1ps
module pmc_bench;
  logic        ref_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rst_pin;
  logic        irq_req;
  logic        core_reset;
  logic        cpu_clk_en;
  logic        fetch_en;
  logic        periph_clk_en;
  logic        irq_wake;
  logic        baud_double;
  logic [7:0]  p0_in;
  logic [7:0]  p0_out;
  logic [7:0]  p0_oe;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          n_checks;

  pmc_top pmc_top_i (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rst_pin(rst_pin), .irq_req(irq_req), .core_reset(core_reset), .cpu_clk_en(cpu_clk_en),
    .fetch_en(fetch_en), .periph_clk_en(periph_clk_en), .irq_wake(irq_wake),
    .baud_double(baud_double), .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd, exp);
    chk("slverr", {31'h0, err}, 32'h0);
  endtask : rdc

  task automatic t_reset();
    rdc("ctl", pmc_pkg::ADDR_PWR_CTL, 32'h0);
    rdc("port", pmc_pkg::ADDR_PORT0, 32'hFF);
    rdc("stat", pmc_pkg::ADDR_STAT, 32'h00003C01);
    chk("oe", p0_oe, 32'h0);
  endtask : t_reset

  task automatic t_regs();
    apb(1'b1, pmc_pkg::ADDR_PWR_CTL, 32'h8C);
    rdc("ctl", pmc_pkg::ADDR_PWR_CTL, 32'h8C);
    chk("baud", baud_double, 32'h1);
    apb(1'b1, pmc_pkg::ADDR_PWR_CTL, 32'h70);
    rdc("ctl", pmc_pkg::ADDR_PWR_CTL, 32'h0);
    chk("baud", baud_double, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped rd", rd, 32'h0);
    apb(1'b1, pmc_pkg::ADDR_STAT, 32'h0);
    rdc("stat", pmc_pkg::ADDR_STAT, 32'h00003C01);
  endtask : t_regs

  task automatic t_port();
    apb(1'b1, pmc_pkg::ADDR_PORT0, 32'h5A);
    #1;
    chk("oe", p0_oe, 32'hA5);
    chk("out", p0_out, 32'h0);
    p0_in <= 8'hC3;
    rdc("stat", pmc_pkg::ADDR_STAT, 32'h0000C301);
  endtask : t_port

  task automatic t_idle();
    apb(1'b1, pmc_pkg::ADDR_PWR_CTL, 32'h01);
    #1;
    chk("clk", cpu_clk_en, 32'h0);
    chk("fetch", fetch_en, 32'h0);
    chk("pclk", periph_clk_en, 32'h1);
    chk("oe", p0_oe, 32'h0);
    rdc("stat", pmc_pkg::ADDR_STAT, 32'h0000C302);
    repeat (5) @(posedge ref_clk);
    #1;
    chk("clk", cpu_clk_en, 32'h0);
    @(posedge ref_clk);
    irq_req <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("wake", irq_wake, 32'h1);
    chk("clk", cpu_clk_en, 32'h1);
    chk("oe", p0_oe, 32'hA5);
    @(posedge ref_clk);
    irq_req <= 1'b0;
    #1;
    chk("wake", irq_wake, 32'h0);
    rdc("ctl", pmc_pkg::ADDR_PWR_CTL, 32'h0);
  endtask : t_idle

  task automatic t_pdown();
    apb(1'b1, pmc_pkg::ADDR_PWR_CTL, 32'h03);
    #1;
    chk("fetch", fetch_en, 32'h0);
    chk("pclk", periph_clk_en, 32'h0);
    chk("oe", p0_oe, 32'h0);
    @(posedge ref_clk);
    irq_req <= 1'b1;
    rst_pin <= 1'b1;
    repeat (10) @(posedge ref_clk);
    irq_req <= 1'b0;
    rst_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("fetch", fetch_en, 32'h0);
    chk("wake", irq_wake, 32'h0);
    chk("rst", core_reset, 32'h0);
    @(posedge ref_clk);
    rst_pin <= 1'b1;
    repeat (23) @(posedge ref_clk);
    #1;
    chk("rst", core_reset, 32'h0);
    @(posedge ref_clk);
    #1;
    chk("rst", core_reset, 32'h1);
    @(posedge ref_clk);
    rst_pin <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("rst", core_reset, 32'h0);
    chk("fetch", fetch_en, 32'h1);
    rdc("ctl", pmc_pkg::ADDR_PWR_CTL, 32'h0);
    rdc("port", pmc_pkg::ADDR_PORT0, 32'hFF);
  endtask : t_pdown

  // idle ended by the reset pin instead of an interrupt
  task automatic t_idle_rst();
    apb(1'b1, pmc_pkg::ADDR_PWR_CTL, 32'h05);
    #1;
    chk("clk", cpu_clk_en, 32'h0);
    @(posedge ref_clk);
    rst_pin <= 1'b1;
    repeat (25) @(posedge ref_clk);
    #1;
    chk("rst", core_reset, 32'h1);
    chk("clk", cpu_clk_en, 32'h1);
    chk("wake", irq_wake, 32'h0);
    @(posedge ref_clk);
    rst_pin <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdc("ctl", pmc_pkg::ADDR_PWR_CTL, 32'h0);
  endtask : t_idle_rst

  // second asynchronous reset in mid-run
  task automatic t_nrst();
    apb(1'b1, pmc_pkg::ADDR_PWR_CTL, 32'h8C);
    apb(1'b1, pmc_pkg::ADDR_PORT0, 32'h00);
    #1;
    chk("oe", p0_oe, 32'hFF);
    chk("baud", baud_double, 32'h1);
    @(posedge ref_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("baud", baud_double, 32'h0);
    chk("oe", p0_oe, 32'h0);
    chk("rst", core_reset, 32'h0);
    @(posedge ref_clk);
    nrst <= 1'b1;
    p0_in <= 8'h3C;
    repeat (4) @(posedge ref_clk);
    t_reset();
  endtask : t_nrst

  initial begin
    n_errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rst_pin = 1'b0;
    irq_req = 1'b0;
    p0_in = 8'h3C;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_regs();
    t_port();
    t_idle();
    t_pdown();
    t_idle_rst();
    t_nrst();
    final_report();
  end
endmodule : pmc_bench
